// ===== inc/psm_consts.vh
// Constants for the sideband status and management pin block
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH
`define PSM_MODE_MII        2'h0
`define PSM_MODE_RMII       2'h1
`define PSM_MODE_RGMII      2'h2
`define PSM_PREAMBLE_BITS   6'h20
`define PSM_OP_WRITE        2'h1
`define PSM_OP_READ         2'h2
`define PSM_REG_CTRL        5'h00
`define PSM_REG_STATUS      5'h01
`define PSM_REG_PIN_CFG     5'h11
`define PSM_REG_IRQ_STAT    5'h12
`define PSM_CTRL_RESET      16'h3100
`define PSM_PIN_CFG_RESET   16'h0000
`define PSM_PIN_CFG_IRQ_BIT 0
`define PSM_CTRL_PWDN_BIT   11
`define PSM_CTRL_SRST_BIT   15
`define PSM_IRQ_LINK_BIT    0
`define PSM_RST_MIN_NS      1000
`define PSM_CLK_PERIOD_NS   50
`define PSM_MDC_MIN_HALF_NS 20
`endif

// ===== hdl/psm_sync2.v
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module psm_sync2 #(
	parameter RESET_VAL = 1'b0
) (
	input  wire ref_clk,
	input  wire rst,
	input  wire d,
	output reg  q
);
	reg meta;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta <= RESET_VAL;
			q    <= RESET_VAL;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // psm_sync2

// ===== hdl/psm_mgmt.v
// Clause 22 management serial engine, stepped by sampled clock edges
`timescale 1ns/1ps
`include "psm_consts.vh"
module psm_mgmt (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire        mdc_rise,
	input  wire        mdc_fall,
	input  wire        mdio_in,
	input  wire [4:0]  phy_addr,
	input  wire [15:0] rd_data,
	output reg         mdio_out,
	output reg         mdio_oe,
	output reg         wr_stb,
	output reg  [4:0]  reg_addr,
	output reg  [15:0] wr_data
);
	localparam S_PRE  = 5'h01;
	localparam S_HEAD = 5'h02;
	localparam S_TA   = 5'h04;
	localparam S_DATA = 5'h08;
	localparam S_IDLE = 5'h10;

	reg [4:0]  state;
	reg [5:0]  cnt;
	reg [13:0] head;
	reg [15:0] shreg;
	reg        is_read;
	reg        mine;

	wire [13:0] next_head = {head[12:0], mdio_in};

	// Input sampled on rising edge, output changed on falling edge
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state    <= S_PRE;
			cnt      <= 6'h00;
			head     <= 14'h0000;
			shreg    <= 16'h0000;
			is_read  <= 1'b0;
			mine     <= 1'b0;
			mdio_out <= 1'b1;
			mdio_oe  <= 1'b0;
			wr_stb   <= 1'b0;
			reg_addr <= 5'h00;
			wr_data  <= 16'h0000;
		end else begin
			wr_stb <= 1'b0;
			if (mdc_fall) begin
				if (state == S_TA && is_read && mine && cnt == 6'h01) begin
					mdio_oe  <= 1'b1;
					mdio_out <= 1'b0;
					shreg    <= rd_data;
				end else if (state == S_DATA && is_read && mine) begin
					mdio_out <= shreg[15];
					shreg    <= {shreg[14:0], 1'b0};
				end else begin
					mdio_oe  <= 1'b0;
					mdio_out <= 1'b1;
				end
			end
			if (mdc_rise) begin
				case (state)
				S_PRE: begin
					if (mdio_in)
						cnt <= (cnt == `PSM_PREAMBLE_BITS) ? cnt
							: cnt + 6'h01;
					else if (cnt == `PSM_PREAMBLE_BITS) begin
						state <= S_HEAD;
						cnt   <= 6'h00;
						head  <= 14'h0000;
					end else
						cnt <= 6'h00;
				end
				S_HEAD: begin
					head <= next_head;
					cnt  <= cnt + 6'h01;
					if (cnt == 6'h0c) begin
						// Start zero ended the preamble; 13 bits remain
						is_read  <= next_head[11:10] == `PSM_OP_READ;
						mine     <= next_head[9:5] == phy_addr;
						reg_addr <= next_head[4:0];
						if (next_head[12] != 1'b1 ||
						    (next_head[11:10] != `PSM_OP_READ &&
						     next_head[11:10] != `PSM_OP_WRITE))
							state <= S_IDLE;
						else
							state <= S_TA;
						cnt <= 6'h00;
					end
				end
				S_TA: begin
					cnt <= cnt + 6'h01;
					if (cnt == 6'h01) begin
						state <= S_DATA;
						cnt   <= 6'h00;
					end
				end
				S_DATA: begin
					wr_data <= {wr_data[14:0], mdio_in};
					cnt     <= cnt + 6'h01;
					if (cnt == 6'h0f) begin
						if (!is_read && mine)
							wr_stb <= 1'b1;
						state <= S_IDLE;
						cnt   <= 6'h00;
					end
				end
				S_IDLE: begin
					state <= S_PRE;
					cnt   <= mdio_in ? 6'h01 : 6'h00;
				end
				default: state <= S_PRE;
				endcase
			end
		end
	end
endmodule // psm_mgmt

// ===== hdl/psm_top.v
// Sideband status, management and power-down/interrupt pin logic
// How it works
// - Four-bit mode: busy output high when receive or transmit active.
// - Reduced-pin mode: one output merges carrier and receive valid.
// - Reduced-gigabit mode: busy/merged output unused, held low.
// - Full duplex: clash output low; unused in reduced-pin mode.
// - Half duplex: clash high only while transmit and receive both busy.
// - Management data sampled and driven on management clock edges only.
// - Data line shared; each side drives in turn, pull-up otherwise.
// - Dual pin is power-down input after reset until configured.
// - Power-down mode while dual pin is low in power-down setting.
// - Interrupt setting: open-drain low while interrupt pending.
// - Low reset pin returns control, pin-config and interrupt registers to initial values.
`timescale 1ns/1ps
`include "psm_consts.vh"
module psm_top (
	input  wire        ref_clk,
	input  wire        rst,
	input  wire [1:0]  if_mode,
	input  wire        full_duplex,
	input  wire        rx_active,
	input  wire        tx_active,
	input  wire        rx_data_valid,
	input  wire        link_up,
	input  wire [4:0]  phy_addr,
	input  wire        mgmt_clk_pin,
	input  wire        mgmt_data_in,
	output reg         mgmt_data_out,
	output reg         mgmt_data_oe,
	input  wire        irq_or_sleep_pin_in,
	output reg         irq_or_sleep_pin_out,
	output reg         irq_or_sleep_pin_oe,
	input  wire        reset_pin_n,
	output reg         medium_busy,
	output reg         medium_clash,
	output reg         power_down
);
	localparam RST_CYC = (`PSM_RST_MIN_NS + `PSM_CLK_PERIOD_NS - 1)
		/ `PSM_CLK_PERIOD_NS;

	wire mdc_s;
	wire mdio_s;
	wire pin_s;
	wire rstn_s;
	wire rx_s;
	wire tx_s;
	wire dv_s;
	wire link_s;
	reg  mdc_d;
	reg  [4:0] rst_cnt;
	reg  soft_rst;
	reg  [15:0] ctrl;
	reg  [15:0] pin_cfg;
	reg  irq_pend;
	reg  link_d;
	wire m_out;
	wire m_oe;
	wire m_wr;
	wire [4:0]  m_addr;
	wire [15:0] m_wdata;
	reg  [15:0] rd_mux;

	wire [7:0] pins_raw = {mgmt_clk_pin, mgmt_data_in, irq_or_sleep_pin_in,
		reset_pin_n, rx_active, tx_active, rx_data_valid, link_up};
	wire [7:0] pins_s;
	// Data, dual and reset pins idle high; the management clock idles low,
	// so no false clock edge follows reset
	localparam [7:0] PIN_IDLE = 8'h70;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
			psm_sync2 #(.RESET_VAL(PIN_IDLE[gi])) u_sync (
				.ref_clk (ref_clk),
				.rst     (rst),
				.d       (pins_raw[gi]),
				.q       (pins_s[gi])
			);
		end
	endgenerate

	assign {mdc_s, mdio_s, pin_s, rstn_s, rx_s, tx_s, dv_s, link_s} = pins_s;

	// Short glitches below one microsecond do not reset the registers
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rst_cnt  <= 5'h00;
			soft_rst <= 1'b0;
		end else if (!rstn_s) begin
			// Fires on the last sample of a minimum-width pulse
			if (rst_cnt != RST_CYC[4:0] - 5'h01)
				rst_cnt <= rst_cnt + 5'h01;
			else
				soft_rst <= 1'b1;
		end else begin
			rst_cnt  <= 5'h00;
			soft_rst <= 1'b0;
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			mdc_d <= 1'b0;
		else
			mdc_d <= mdc_s;
	end

	psm_mgmt u_mgmt (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.mdc_rise (mdc_s & ~mdc_d),
		.mdc_fall (~mdc_s & mdc_d),
		.mdio_in  (mdio_s),
		.phy_addr (phy_addr),
		.rd_data  (rd_mux),
		.mdio_out (m_out),
		.mdio_oe  (m_oe),
		.wr_stb   (m_wr),
		.reg_addr (m_addr),
		.wr_data  (m_wdata)
	);

	always @* begin
		case (m_addr)
		`PSM_REG_CTRL:     rd_mux = ctrl;
		`PSM_REG_STATUS:   rd_mux = {13'h0000, link_s, full_duplex, 1'b0};
		`PSM_REG_PIN_CFG:  rd_mux = pin_cfg;
		`PSM_REG_IRQ_STAT: rd_mux = {15'h0000, irq_pend};
		default:           rd_mux = 16'h0000;
		endcase
	end

	// Reading the status clears it unless a new event lands the same cycle
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl     <= `PSM_CTRL_RESET;
			pin_cfg  <= `PSM_PIN_CFG_RESET;
			irq_pend <= 1'b0;
			link_d   <= 1'b0;
		end else if (soft_rst || ctrl[`PSM_CTRL_SRST_BIT]) begin
			ctrl     <= `PSM_CTRL_RESET;
			pin_cfg  <= `PSM_PIN_CFG_RESET;
			irq_pend <= 1'b0;
			link_d   <= link_s;
		end else begin
			link_d <= link_s;
			if (m_wr && m_addr == `PSM_REG_CTRL)
				ctrl <= m_wdata;
			if (m_wr && m_addr == `PSM_REG_PIN_CFG)
				pin_cfg <= m_wdata;
			if (link_s != link_d)
				irq_pend <= 1'b1;
			else if (m_oe && m_addr == `PSM_REG_IRQ_STAT && mdc_s && !mdc_d)
				irq_pend <= 1'b0;
		end
	end

	wire irq_mode = pin_cfg[`PSM_PIN_CFG_IRQ_BIT];

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			medium_busy          <= 1'b0;
			medium_clash         <= 1'b0;
			power_down           <= 1'b0;
			mgmt_data_out        <= 1'b1;
			mgmt_data_oe         <= 1'b0;
			irq_or_sleep_pin_out <= 1'b0;
			irq_or_sleep_pin_oe  <= 1'b0;
		end else begin
			case (if_mode)
			`PSM_MODE_MII:  medium_busy <= rx_s | tx_s;
			`PSM_MODE_RMII: medium_busy <= rx_s | dv_s;
			default:        medium_busy <= 1'b0;
			endcase
			if (full_duplex || if_mode != `PSM_MODE_MII)
				medium_clash <= 1'b0;
			else
				medium_clash <= rx_s & tx_s;
			power_down <= ctrl[`PSM_CTRL_PWDN_BIT] |
				(!irq_mode & !pin_s);
			mgmt_data_out <= m_out;
			mgmt_data_oe  <= m_oe;
			irq_or_sleep_pin_out <= 1'b0;
			irq_or_sleep_pin_oe  <= irq_mode & irq_pend;
		end
	end
endmodule // psm_top

// ===== testbench/psm_assertions.sv
// Concurrent checks on the status and management pins
`timescale 1ns/1ps
module psm_chk (
	input wire       ref_clk,
	input wire       rst,
	input wire [1:0] if_mode,
	input wire       full_duplex,
	input wire       rx_active,
	input wire       tx_active,
	input wire       rx_data_valid,
	input wire       mgmt_clk_pin,
	input wire       mgmt_data_out,
	input wire       mgmt_data_oe,
	input wire       irq_or_sleep_pin_out,
	input wire       irq_or_sleep_pin_oe,
	input wire       medium_busy,
	input wire       medium_clash
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	reg  [1:0] age;
	// Outputs trail the pins by three edges, so hold off until history is real
	always @(posedge ref_clk or posedge rst)
		if (rst)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	busy_mii_a: assert property (age == 2'h3 && if_mode == 2'h0 &&
		$past(if_mode, 3) == 2'h0 |-> medium_busy ==
		($past(rx_active, 3) | $past(tx_active, 3))) else $error("busy mii");
	busy_rmii_a: assert property (age == 2'h3 && if_mode == 2'h1 &&
		$past(if_mode, 3) == 2'h1 |-> medium_busy ==
		($past(rx_active, 3) | $past(rx_data_valid, 3))) else $error("busy rm");
	busy_rgmii_a: assert property (age == 2'h3 && if_mode[1] &&
		$past(if_mode[1], 3) |-> !medium_busy) else $error("busy rg");
	clash_full_a: assert property (age == 2'h3 && full_duplex &&
		$past(full_duplex, 3) |-> !medium_clash) else $error("clash full");
	clash_half_a: assert property (age == 2'h3 && !full_duplex &&
		!$past(full_duplex, 3) && if_mode == 2'h0 && $past(if_mode, 3) == 2'h0
		|-> medium_clash == ($past(rx_active, 3) & $past(tx_active, 3)))
		else $error("clash half");
	data_edge_a: assert property ($rose(mgmt_clk_pin) |=>
		$stable(mgmt_data_out)[*4]) else $error("data moved on rise");
	turn_zero_a: assert property ($rose(mgmt_data_oe) |->
		!mgmt_data_out) else $error("turnaround not low");
	pin_input_a: assert property ($fell(rst) |->
		!irq_or_sleep_pin_oe[*8]) else $error("pin driven after reset");
	open_drain_a: assert property (irq_or_sleep_pin_oe |->
		!irq_or_sleep_pin_out) else $error("pin driven high");
endmodule // psm_chk

// ===== testbench/psm_station.sv
// Management station model with a pulled-up shared data line
`timescale 1ns/1ps
module psm_station (
	input  wire dev_out,
	input  wire dev_oe,
	output reg  mclk,
	output wire line
);
	reg sd;
	reg soe;
	// Released line floats to the pull-up level
	assign line = dev_oe ? dev_out : (soe ? sd : 1'b1);
	initial begin
		mclk = 1'b0;
		sd = 1'b1;
		soe = 1'b0;
	end
	// Clock stands low between frames; 400 ns period
	task xfer(input [63:0] f, input wr, output [15:0] rd);
		integer i;
		begin
			rd = 16'h0;
			for (i = 0; i < 64; i = i + 1) begin
				mclk = 1'b0;
				soe = wr || i < 46;
				sd = f[63 - i];
				#200;
				mclk = 1'b1;
				if (i >= 48)
					rd = {rd[14:0], line};
				#200;
			end
			mclk = 1'b0;
			soe = 1'b0;
		end
	endtask
endmodule // psm_station

// ===== testbench/psm_top_tb.sv
// Self-checking bench for the sideband status and management pins
`timescale 1ns/1ps
`include "psm_consts.vh"
module psm_top_tb;
	reg        ref_clk, rst, full_duplex, rx_active, tx_active;
	reg        rx_data_valid, link_up, reset_pin_n, sleep_n;
	reg  [1:0] if_mode;
	reg  [7:0] lfsr;
	reg [15:0] rd;
	wire [4:0] phy_addr = 5'h01;
	wire       mgmt_clk_pin, mgmt_data_in, mgmt_data_out, mgmt_data_oe;
	wire       irq_or_sleep_pin_out, irq_or_sleep_pin_oe, power_down;
	wire       medium_busy, medium_clash;
	integer    err_count, checks, m, k;
	// Open drain: only a low is ever driven onto the pin
	wire irq_or_sleep_pin_in = irq_or_sleep_pin_oe ? 1'b0 : sleep_n;
	psm_top dut (.*);
	psm_station u_sta (
		.dev_out (mgmt_data_out),
		.dev_oe  (mgmt_data_oe),
		.mclk    (mgmt_clk_pin),
		.line    (mgmt_data_in)
	);
	function [7:0] nxt(input [7:0] v);
		nxt = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function exp_busy(input [1:0] md, input r, input t, input v);
		exp_busy = md == 2'h0 ? r | t : (md == 2'h1 ? r | v : 1'b0);
	endfunction
	function exp_clash(input [1:0] md, input fd, input r, input t);
		exp_clash = md == 2'h0 && !fd && r && t;
	endfunction
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("wrong value at %0t: %h, expected %h", $time, got, exp);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d, errors %0d", checks, err_count);
			if (err_count == 0 && checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task mg(input [1:0] op, input [4:0] ra, input [15:0] d);
		u_sta.xfer({32'hffffffff, 2'b01, op, phy_addr, ra, 2'b10, d},
			op == `PSM_OP_WRITE, rd);
	endtask
	task wt(input integer n);
		begin
			repeat (n) @(posedge ref_clk);
			#1;
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		#2000000;
		err_count = err_count + 1;
		conclude;
	end
	initial begin
		{err_count, checks} = 0;
		{rst, reset_pin_n, sleep_n} = 3'h7;
		{if_mode, full_duplex, rx_active, tx_active} = 5'h00;
		{rx_data_valid, link_up} = 2'h0;
		lfsr = 8'd68;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		// Every mode and duplex; first draw forces both media busy
		for (m = 0; m < 8; m = m + 1)
			for (k = 0; k < 8; k = k + 1) begin
				lfsr = nxt(lfsr);
				@(posedge ref_clk);
				if_mode <= m / 2;
				full_duplex <= m % 2;
				rx_active <= k == 0 || lfsr[0];
				tx_active <= k == 0 || lfsr[1];
				rx_data_valid <= lfsr[2];
				wt(5);
				cmp(medium_busy, exp_busy(if_mode, rx_active, tx_active,
					rx_data_valid));
				cmp(medium_clash, exp_clash(if_mode, full_duplex, rx_active,
					tx_active));
			end
		@(posedge ref_clk);
		sleep_n <= 1'b0;
		wt(5);
		cmp(power_down, 1'b1);
		@(posedge ref_clk);
		sleep_n <= 1'b1;
		wt(5);
		cmp(power_down, 1'b0);
		mg(`PSM_OP_READ, `PSM_REG_CTRL, 16'h0);
		cmp(rd, `PSM_CTRL_RESET);
		mg(`PSM_OP_WRITE, `PSM_REG_PIN_CFG, 16'h0001);
		@(posedge ref_clk);
		link_up <= 1'b1;
		wt(8);
		cmp(irq_or_sleep_pin_oe, 1'b1);
		cmp(power_down, 1'b0);
		mg(`PSM_OP_READ, `PSM_REG_IRQ_STAT, 16'h0);
		cmp(rd, 16'h0001);
		wt(8);
		cmp(irq_or_sleep_pin_oe, 1'b0);
		@(posedge ref_clk);
		reset_pin_n <= 1'b0;
		wt(25);
		@(posedge ref_clk);
		reset_pin_n <= 1'b1;
		wt(6);
		mg(`PSM_OP_READ, `PSM_REG_PIN_CFG, 16'h0);
		cmp(rd, `PSM_PIN_CFG_RESET);
		conclude;
	end
endmodule // psm_top_tb
bind psm_top psm_chk u_chk (.*);
